// ==== logic/aclb_pkg.sv ====
package aclb_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_FORMAT = 8'h70; // Frame format control
  localparam logic [7:0] ADDR_CTRL = 8'h71; // Companding and loopback control
  localparam logic [7:0] ADDR_STATUS = 8'h72; // Interface status, read only

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_LOOP_BIT = 0;
  localparam int CTRL_TX_LAW_BIT = 4;
  localparam int CTRL_TX_COMP_BIT = 5;
  localparam int CTRL_RX_LAW_BIT = 6;
  localparam int CTRL_RX_COMP_BIT = 7;
  localparam int FMT_POL_BIT = 0;
  localparam int STAT_WORD8_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_CODE_LSB = 8;
  localparam int CODE_BITS = 8;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic CTRL_LOOP_RST = 1'b0;
  localparam logic CTRL_LAW_RST = 1'b0;
  localparam logic CTRL_COMP_RST = 1'b0;
  localparam logic FMT_POL_RST = 1'b0;
  localparam logic [15:0] REG_ZERO = 16'h0000;

  // ****************************************
  // Word and frame lengths in bit clocks
  // ****************************************
  localparam logic [5:0] FULL_WORD_BITS = 6'h10;
  localparam logic [5:0] BYTE_WORD_BITS = 6'h08;
  localparam logic [5:0] FULL_FRAME_BITS = 6'h20;
  localparam logic [5:0] BYTE_FRAME_BITS = 6'h10;

  // ****************************************
  // Companding constants
  // ****************************************
  localparam logic [15:0] MU_BIAS = 16'h0084;
  localparam logic [15:0] MU_CLIP = 16'h7F7B;
  localparam logic [7:0] A_EVEN_MASK = 8'h55;
  localparam logic [15:0] A_SEG0_OFS = 16'h0008;
  localparam logic [15:0] A_SEG1_OFS = 16'h0108;

  // ****************************************
  // Frame tracking states
  // ****************************************
  typedef enum logic [1:0] {
    AF_IDLE = 2'b00,
    AF_ARM = 2'b01,
    AF_DATA = 2'b10
  } aclb_frame_state_t;

endpackage : aclb_pkg

// ==== logic/aclb_g711.sv ====
`timescale 1ns/1ps
module aclb_g711 import aclb_pkg::*; (
  // Compressor side
  input wire logic [15:0] lin_in,
  input wire logic tx_alaw,
  output logic [7:0] code_out,
  // Expander side
  input wire logic [7:0] code_in,
  input wire logic rx_alaw,
  output logic [15:0] lin_out
);

  // ****************************************
  // Segment search
  // ****************************************
  // Index of highest set bit, zero when none
  function automatic logic [2:0] seg_of(input logic [7:0] w);
    logic [2:0] s;
    s = 3'h0;
    for (int i = 1; i < 8; i++) begin
      if (w[i]) begin
        s = 3'(i);
      end
    end
    return s;
  endfunction : seg_of

  logic mu_neg, a_neg;
  logic [15:0] mu_mag, mu_clip, mu_biased, mu_shift;
  logic [2:0] mu_exp, a_seg;
  logic [11:0] a_mag, a_shift;
  logic [7:0] mu_code, a_code;
  logic [7:0] mu_inv, a_un;
  logic [15:0] mu_t, mu_lin, a_base, a_t, a_lin;

  // ****************************************
  // Compressor
  // ****************************************
  // Biased 13-bit magnitude to sign, segment, mantissa
  always_comb begin
    mu_neg = lin_in[15];
    mu_mag = mu_neg ? (~lin_in + 16'h0001) : lin_in;
    mu_clip = (mu_mag > MU_CLIP) ? MU_CLIP : mu_mag;
    mu_biased = mu_clip + MU_BIAS;
    mu_exp = seg_of(mu_biased[14:7]);
    mu_shift = mu_biased >> ({1'b0, mu_exp} + 4'h3);
    mu_code = ~{mu_neg, mu_exp, mu_shift[3:0]};
  end

  // A-law: 12-bit magnitude, one's complement for negatives
  always_comb begin
    a_neg = lin_in[15];
    a_mag = a_neg ? ~lin_in[14:3] : lin_in[14:3];
    a_seg = seg_of({a_mag[11:5], 1'b0});
    a_shift = (a_seg < 3'h2) ? (a_mag >> 1) : (a_mag >> a_seg);
    a_code = {~a_neg, a_seg, a_shift[3:0]} ^ A_EVEN_MASK;
    code_out = tx_alaw ? a_code : mu_code;
  end

  // ****************************************
  // Expander
  // ****************************************
  // Undo inversion first, then rebuild the linear value
  always_comb begin
    mu_inv = ~code_in;
    mu_t = ({9'h000, mu_inv[3:0], 3'h0} + MU_BIAS) << mu_inv[6:4];
    mu_lin = mu_inv[7] ? (MU_BIAS - mu_t) : (mu_t - MU_BIAS);
    a_un = code_in ^ A_EVEN_MASK;
    a_base = {8'h00, a_un[3:0], 4'h0} + ((a_un[6:4] == 3'h0) ? A_SEG0_OFS : A_SEG1_OFS);
    a_t = (a_un[6:4] <= 3'h1) ? a_base : (a_base << (a_un[6:4] - 3'h1));
    a_lin = a_un[7] ? a_t : (~a_t + 16'h0001);
    lin_out = rx_alaw ? a_lin : mu_lin;
  end

endmodule : aclb_g711

// ==== logic/aclb_top.sv ====
// How it works
// - Loopback bit feeds ADC samples to DAC
// - Separate transmit and receive companding enables
// - Transmit law bit: 0 mu, 1 A
// - Receive law bit: 0 mu, 1 A
// - Segment approximation of both G.711 laws
// - Invert all bits mu, even bits A
// - Code byte sits in word MSBs
// - 13 or 12 bit magnitude to byte
// - Byte is sign, exponent, mantissa
// - Any companding enable selects 8-bit words
// - 8-bit words run back to back
// - Law bit alone gives plain 8-bit words
// - Mode B MSB first edge, A second
`timescale 1ns/1ps
module aclb_top import aclb_pkg::*; (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Serial audio interface
  input wire logic aif_bclk,
  input wire logic aif_frame,
  input wire logic aif_rx_data,
  output logic aif_tx_data,
  // Converter side
  input wire logic [15:0] adc_left,
  input wire logic [15:0] adc_right,
  output logic [15:0] dac_left,
  output logic [15:0] dac_right,
  output logic dac_left_stb,
  output logic dac_right_stb
);

  // ****************************************
  // Declarations
  // ****************************************
  logic loop_en;
  logic tx_law_sel;
  logic tx_comp_en;
  logic rx_law_sel;
  logic rx_comp_en;
  logic frame_polarity_sel;
  logic word8;
  logic [5:0] word_bits;
  logic [5:0] frame_bits;
  logic bclk_q;
  logic frame_at_edge;
  logic bclk_rise;
  logic frame_start;
  logic take_bit;
  logic [5:0] cur_idx;
  logic left_end;
  logic right_end;
  aclb_frame_state_t state;
  aclb_frame_state_t next_state;
  logic [5:0] bit_cnt;
  logic [31:0] tx_shift;
  logic [31:0] rx_shift;
  logic [31:0] next_rx;
  logic [31:0] tx_load;
  logic [7:0] last_code;
  logic [15:0] rd_value;
  logic [15:0] adc_word [2];
  logic [7:0] tx_code [2];
  logic [15:0] rx_lin [2];
  logic [15:0] rx_word [2];

  assign adc_word[0] = adc_left;
  assign adc_word[1] = adc_right;

  // ****************************************
  // Companders, one per channel
  // ****************************************
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    aclb_g711 u_codec (
      .lin_in(adc_word[ch]),
      .tx_alaw(tx_law_sel),
      .code_out(tx_code[ch]),
      .code_in(next_rx[7:0]),
      .rx_alaw(rx_law_sel),
      .lin_out(rx_lin[ch])
    );

    // Received word to linear, by word mode
    always_comb begin
      if (!word8) begin
        rx_word[ch] = next_rx[15:0];
      end else if (rx_comp_en) begin
        rx_word[ch] = rx_lin[ch];
      end else begin
        rx_word[ch] = {next_rx[7:0], 8'h00};
      end
    end
  end

  // ****************************************
  // Word mode
  // ****************************************
  // Either enable or either law bit shortens words
  assign word8 = tx_comp_en | rx_comp_en | tx_law_sel | rx_law_sel;
  assign word_bits = word8 ? BYTE_WORD_BITS : FULL_WORD_BITS;
  assign frame_bits = word8 ? BYTE_FRAME_BITS : FULL_FRAME_BITS;

  // Next transmit pair, code bytes in the top bits
  always_comb begin
    if (!word8) begin
      tx_load = {adc_word[0], adc_word[1]};
    end else if (tx_comp_en) begin
      tx_load = {tx_code[0], tx_code[1], 16'h0000};
    end else begin
      tx_load = {adc_word[0][15:8], adc_word[1][15:8], 16'h0000};
    end
  end

  // ****************************************
  // Bit clock and frame tracking
  // ****************************************
  // Pins are synchronous; keep last bit clock level
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bclk_q <= 1'b0;
    end else if (clk_en) begin
      bclk_q <= aif_bclk;
    end
  end

  // Frame level seen at the last bit clock edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_at_edge <= 1'b0;
    end else if (clk_en && bclk_rise) begin
      frame_at_edge <= aif_frame;
    end
  end

  assign bclk_rise = aif_bclk & ~bclk_q;
  assign frame_start = bclk_rise & aif_frame & ~frame_at_edge;

  // Mode B takes the start edge as MSB, mode A waits one
  always_comb begin
    take_bit = 1'b0;
    cur_idx = bit_cnt;
    if (frame_start) begin
      take_bit = frame_polarity_sel;
      cur_idx = 6'h00;
    end else if (bclk_rise && state == AF_ARM) begin
      take_bit = 1'b1;
      cur_idx = 6'h00;
    end else if (bclk_rise && state == AF_DATA) begin
      take_bit = 1'b1;
    end
  end

  // Word ends; right word follows the left at once
  assign left_end = take_bit && (cur_idx == word_bits - 6'h01);
  assign right_end = take_bit && (cur_idx == frame_bits - 6'h01);

  // Frame state transitions; a new start always wins
  always_comb begin
    next_state = state;
    case (state)
      AF_IDLE: begin
        next_state = AF_IDLE;
      end
      AF_ARM: begin
        next_state = AF_DATA;
      end
      AF_DATA: begin
        next_state = AF_DATA;
      end
      default: begin
        next_state = AF_IDLE;
      end
    endcase
    if (frame_start) begin
      next_state = frame_polarity_sel ? AF_DATA : AF_ARM;
    end else if (!bclk_rise) begin
      next_state = state;
    end
    if (right_end) begin
      next_state = AF_IDLE;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= AF_IDLE;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // Bit position within the frame
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt <= 6'h00;
    end else if (clk_en) begin
      if (frame_start && !frame_polarity_sel) begin
        bit_cnt <= 6'h00;
      end else if (take_bit) begin
        bit_cnt <= cur_idx + 6'h01;
      end
    end
  end

  // ****************************************
  // Serial shifters
  // ****************************************
  assign next_rx = {rx_shift[30:0], aif_rx_data};

  // Receive shifter, MSB first
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_shift <= 32'h0000_0000;
    end else if (clk_en && take_bit) begin
      rx_shift <= next_rx;
    end
  end

  // Transmit shifter; MSB waits on the line between frames
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_shift <= 32'h0000_0000;
    end else if (clk_en) begin
      if (right_end) begin
        tx_shift <= tx_load;
      end else if (take_bit) begin
        tx_shift <= {tx_shift[30:0], 1'b0};
      end
    end
  end

  assign aif_tx_data = tx_shift[31];

  // ****************************************
  // Converter outputs
  // ****************************************
  // Left sample at end of left word
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dac_left <= 16'h0000;
      dac_left_stb <= 1'b0;
    end else if (clk_en) begin
      dac_left_stb <= left_end;
      if (left_end) begin
        dac_left <= loop_en ? adc_left : rx_word[0];
      end
    end
  end

  // Right sample at end of frame
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dac_right <= 16'h0000;
      dac_right_stb <= 1'b0;
    end else if (clk_en) begin
      dac_right_stb <= right_end;
      if (right_end) begin
        dac_right <= loop_en ? adc_right : rx_word[1];
      end
    end
  end

  // Last received low byte, for status
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      last_code <= 8'h00;
    end else if (clk_en && (left_end || right_end)) begin
      last_code <= next_rx[7:0];
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  // Companding and loopback control
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      loop_en <= CTRL_LOOP_RST;
      tx_law_sel <= CTRL_LAW_RST;
      tx_comp_en <= CTRL_COMP_RST;
      rx_law_sel <= CTRL_LAW_RST;
      rx_comp_en <= CTRL_COMP_RST;
    end else if (clk_en && reg_wr && reg_addr == ADDR_CTRL) begin
      loop_en <= reg_wdata[CTRL_LOOP_BIT];
      tx_law_sel <= reg_wdata[CTRL_TX_LAW_BIT];
      tx_comp_en <= reg_wdata[CTRL_TX_COMP_BIT];
      rx_law_sel <= reg_wdata[CTRL_RX_LAW_BIT];
      rx_comp_en <= reg_wdata[CTRL_RX_COMP_BIT];
    end
  end

  // Frame format control
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_polarity_sel <= FMT_POL_RST;
    end else if (clk_en && reg_wr && reg_addr == ADDR_FORMAT) begin
      frame_polarity_sel <= reg_wdata[FMT_POL_BIT];
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  // Read mux; unmapped and reserved bits are zero
  always_comb begin
    rd_value = REG_ZERO;
    if (reg_addr == ADDR_FORMAT) begin
      rd_value[FMT_POL_BIT] = frame_polarity_sel;
    end else if (reg_addr == ADDR_CTRL) begin
      rd_value[CTRL_LOOP_BIT] = loop_en;
      rd_value[CTRL_TX_LAW_BIT] = tx_law_sel;
      rd_value[CTRL_TX_COMP_BIT] = tx_comp_en;
      rd_value[CTRL_RX_LAW_BIT] = rx_law_sel;
      rd_value[CTRL_RX_COMP_BIT] = rx_comp_en;
    end else if (reg_addr == ADDR_STATUS) begin
      rd_value[STAT_WORD8_BIT] = word8;
      rd_value[STAT_BUSY_BIT] = (state != AF_IDLE);
      rd_value[STAT_CODE_LSB +: CODE_BITS] = last_code;
    end
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= REG_ZERO;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rd_value : REG_ZERO;
    end
  end

endmodule : aclb_top

// ==== tb/aclb_monitor.sv ====
`timescale 1ns/1ps
module aclb_monitor import aclb_pkg::*; (
  // Clock and register port
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Serial link and converters
  input wire logic aif_bclk,
  input wire logic aif_frame,
  input wire logic aif_rx_data,
  input wire logic aif_tx_data,
  input wire logic [15:0] adc_left,
  input wire logic [15:0] adc_right,
  input wire logic [15:0] dac_left,
  input wire logic [15:0] dac_right,
  input wire logic dac_left_stb,
  input wire logic dac_right_stb
);
  logic [7:0] ctrl;
  logic rd_c;
  logic rd_s;
  // Taken reads of control and status
  assign rd_c = clk_en && reg_rd && reg_addr == ADDR_CTRL;
  assign rd_s = clk_en && reg_rd && reg_addr == ADDR_STATUS;
  // Shadow of the control register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= 8'h00;
    end else if (clk_en && reg_wr && reg_addr == ADDR_CTRL) begin
      ctrl <= reg_wdata[7:0] & 8'hF1;
    end
  end
  // ********
  // Properties
  // ********
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_loop_stb;
    ctrl[CTRL_LOOP_BIT] && dac_left_stb;
  endsequence
  property p_ctrl_rd;
    rd_c |=> reg_rdata == {8'h00, ctrl};
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback");
  property p_word8;
    rd_s |=> reg_rdata[STAT_WORD8_BIT] == (ctrl[7:4] != 4'h0);
  endproperty
  a_word8: assert property (p_word8) else $error("word mode");
  property p_loop;
    s_loop_stb |-> dac_left == $past(adc_left);
  endproperty
  a_loop: assert property (p_loop) else $error("loopback data");
  property p_tx_edge;
    $changed(aif_tx_data) |-> $past(aif_bclk) || $past(aif_bclk, 2);
  endproperty
  a_tx_edge: assert property (p_tx_edge) else $error("tx off edge");
  property p_dac_edge;
    dac_left_stb || dac_right_stb |-> $past(aif_bclk) || $past(aif_bclk, 2);
  endproperty
  a_dac_edge: assert property (p_dac_edge) else $error("dac off edge");
  property p_stb_pulse;
    dac_left_stb |=> !dac_left_stb && !dac_right_stb;
  endproperty
  a_stb_pulse: assert property (p_stb_pulse) else $error("strobe width");
  property p_plain8;
    ctrl[7:4] != 4'h0 && ctrl[7:0] < 8'h80 && !ctrl[0] && dac_left_stb |-> dac_left[7:0] == 8'h00;
  endproperty
  a_plain8: assert property (p_plain8) else $error("plain byte");
  property p_expand;
    ctrl[7] && !ctrl[0] && dac_right_stb |-> (dac_right[2:0] & {ctrl[6], 2'b11}) == 3'b000;
  endproperty
  a_expand: assert property (p_expand) else $error("expand scale");
endmodule : aclb_monitor
bind aclb_top aclb_monitor u_mon (.*);

// ==== tb/aclb_host.sv ====
`timescale 1ns/1ps
module aclb_host (
  // Bench clock
  input wire logic core_clk,
  // Serial audio interface
  output logic aif_bclk,
  output logic aif_frame,
  output logic aif_rx_data,
  input wire logic aif_tx_data
);
  // Link clock still and low outside frames
  initial begin
    aif_bclk = 1'b0;
    aif_frame = 1'b0;
    aif_rx_data = 1'b0;
  end
  // One frame, left then right word back to back
  task automatic xfer(input int w, input bit mb, input logic [15:0] l, input logic [15:0] r,
    output logic [15:0] tl, output logic [15:0] tr);
    logic [31:0] sh;
    int b;
    sh = (w == 16) ? {l, r} : {l[15:8], r[15:8], 16'h0000};
    tl = 16'h0000;
    tr = 16'h0000;
    for (int i = 0; i < 2 * w + 1 - int'(mb); i++) begin
      b = i - 1 + int'(mb);
      @(posedge core_clk);
      aif_bclk <= 1'b0;
      aif_frame <= (i == 0);
      aif_rx_data <= (b >= 0) ? sh[31 - b] : ~aif_rx_data;
      repeat (2) @(posedge core_clk);
      aif_bclk <= 1'b1;
      @(posedge core_clk);
      if (b >= 0 && b < w) tl[15 - b] = aif_tx_data;
      if (b >= w) tr[15 - b + w] = aif_tx_data;
    end
    @(posedge core_clk);
    aif_bclk <= 1'b0;
    aif_frame <= 1'b0;
    aif_rx_data <= ~aif_rx_data;
  endtask : xfer
endmodule : aclb_host

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top import aclb_pkg::*;;
  logic core_clk = 1'b0;
  logic arst_n, clk_en, reg_wr, reg_rd, rd_seen;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, adc_left, adc_right, dac_left, dac_right;
  logic aif_bclk, aif_frame, aif_rx_data, aif_tx_data, dac_left_stb, dac_right_stb;
  logic [31:0] ev;
  logic [31:0] q_reg[$];
  logic [15:0] q_dac[$];
  logic [15:0] modes [9] = '{16'h0000, 16'h0000, 16'h0010, 16'h0040, 16'h00A0,
    16'h00F0, 16'h0030, 16'h00C0, 16'h0001};
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  aclb_top uut (.*);
  aclb_host host (.core_clk, .aif_bclk, .aif_frame, .aif_rx_data, .aif_tx_data);
  // 10 MHz clock
  always #50 core_clk = ~core_clk;
  // ********
  // Reference companding
  // ********
  function automatic logic [7:0] mu_enc(input logic [15:0] x);
    logic [15:0] m;
    int e;
    m = x[15] ? -x : x;
    if (m > MU_CLIP) m = MU_CLIP;
    m = m + MU_BIAS;
    e = 7;
    while (e > 0 && !m[e + 7]) e--;
    return ~{x[15], 3'(e), m[e + 3 +: 4]};
  endfunction : mu_enc
  function automatic logic [7:0] a_enc(input logic [15:0] x);
    logic [12:0] v;
    int s;
    v = x[15] ? ~x[15:3] : x[15:3];
    s = 0;
    while (v > 13'((32 << s) - 1)) s++;
    return {~x[15], 3'(s), s < 2 ? v[4:1] : v[s +: 4]} ^ A_EVEN_MASK;
  endfunction : a_enc
  function automatic logic [15:0] mu_dec(input logic [7:0] c);
    logic [15:0] t;
    t = ({12'h000, ~c[3:0]} << 3) + MU_BIAS;
    t = t << 3'(~c[6:4]);
    return c[7] ? t - MU_BIAS : MU_BIAS - t;
  endfunction : mu_dec
  function automatic logic [15:0] a_dec(input logic [7:0] c);
    logic [7:0] a;
    logic [15:0] t;
    a = c ^ A_EVEN_MASK;
    t = {8'h00, a[3:0], 4'h0} + (a[6:4] == 3'h0 ? A_SEG0_OFS : A_SEG1_OFS);
    if (a[6:4] > 3'h1) t = t << (a[6:4] - 3'h1);
    return a[7] ? t : -t;
  endfunction : a_dec
  function automatic logic [15:0] rx_exp(input logic [15:0] d, input logic [7:0] c);
    if (c[7]) return c[6] ? a_dec(d[15:8]) : mu_dec(d[15:8]);
    return c[7:4] != 4'h0 ? {d[15:8], 8'h00} : d;
  endfunction : rx_exp
  function automatic logic [15:0] tx_exp(input logic [15:0] d, input logic [7:0] c);
    if (c[5]) return {c[4] ? a_enc(d) : mu_enc(d), 8'h00};
    return c[7:4] != 4'h0 ? {d[15:8], 8'h00} : d;
  endfunction : tx_exp
  // ********
  // Bus tasks and report
  // ********
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    q_reg.push_back({m, e});
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  // Compare read data and converter words with the oldest note
  always @(posedge core_clk) begin
    if (rd_seen === 1'b1) begin
      // A read with no note left can never match
      ev = {16'hFFFF, ~reg_rdata};
      if (q_reg.size()) ev = q_reg.pop_front();
      check(reg_rdata & ev[31:16], ev[15:0]);
    end
    rd_seen <= reg_rd && clk_en;
    if (dac_left_stb === 1'b1 || dac_right_stb === 1'b1) begin
      ev = {16'h0000, ~(dac_left_stb === 1'b1 ? dac_left : dac_right)};
      if (q_dac.size()) ev = 32'(q_dac.pop_front());
      check(dac_left_stb === 1'b1 ? dac_left : dac_right, ev[15:0]);
    end
  end
  // Cut a hung run short
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  // Main sequence
  initial begin
    logic [15:0] ctl, l, r, la, ra, tl, tr;
    int w;
    {arst_n, clk_en, reg_wr, reg_rd, rd_seen} = 5'b01000;
    {reg_addr, reg_wdata, adc_left, adc_right} = '0;
    w = $urandom(99886);
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(ADDR_CTRL, 16'h0000, 16'hFFFF);
    wr(8'h55, 16'hFFFF);
    wr(ADDR_STATUS, 16'hFFFF);
    rd(8'h55, 16'h0000, 16'hFFFF);
    rd(ADDR_STATUS, 16'h0000, 16'h0001);
    wr(ADDR_CTRL, 16'hFFFF);
    rd(ADDR_CTRL, 16'h00F1, 16'hFFFF);
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(ADDR_CTRL, 16'h0000);
    clk_en <= 1'b1;
    rd(ADDR_CTRL, 16'h00F1, 16'hFFFF);
    for (int i = 0; i < 9; i++) begin
      ctl = modes[i];
      w = (ctl[7:4] != 4'h0) ? 8 : 16;
      wr(ADDR_FORMAT, {15'h0000, i[0]});
      wr(ADDR_CTRL, ctl);
      rd(ADDR_STATUS, {15'h0000, w == 8}, 16'h0001);
      la = 16'($urandom);
      ra = 16'($urandom);
      adc_left <= la;
      adc_right <= ra;
      repeat (2) begin
        l = 16'($urandom);
        r = 16'($urandom);
        q_dac.push_back(ctl[0] ? la : rx_exp(l, ctl[7:0]));
        q_dac.push_back(ctl[0] ? ra : rx_exp(r, ctl[7:0]));
        host.xfer(w, i[0], l, r, tl, tr);
      end
      // Idle after the frame, last received byte kept
      rd(ADDR_STATUS, {(w == 8) ? r[15:8] : r[7:0], 7'h00, w == 8}, 16'hFF03);
      rd(ADDR_FORMAT, {15'h0000, i[0]}, 16'hFFFF);
      check(tl, tx_exp(la, ctl[7:0]));
      check(tr, tx_exp(ra, ctl[7:0]));
    end
    repeat (10) @(posedge core_clk);
    check(16'(q_dac.size() + q_reg.size()), 16'h0000);
    final_report();
  end
endmodule : tb_top
